// *** cpf_assertions.sv ***
`timescale 1ns/100ps
module cpf_assertions
	import cpf_pkg::*;
(
	input wire logic                  CLK,
	input wire logic                  RST_N,
	input wire logic                  CE,
	input wire logic                  HSEL,
	input wire logic [31:0]           HADDR,
	input wire logic [1:0]            HTRANS,
	input wire logic                  HWRITE,
	input wire logic [31:0]           HWDATA,
	input wire logic                  HREADY,
	input wire cpf_req_s              REQ,
	input wire cpf_bus_s              BUS,
	input wire cpf_rsp_s              RSP,
	input wire cpf_io_s               IO_UNIT0_SIDEBAND_INFO,
	input wire cpf_io_s               IO_UNIT1_SIDEBAND_INFO,
	input wire logic [1:0][INC_W-1:0] INC
);
	logic        wp;
	logic [7:0]  wa;
	logic [4:0]  s0;
	logic [4:0]  s1;
	logic [31:0] q0;
	logic [31:0] q1;
	logic        e_wr;
	logic        e_cmd;
	logic        e_rsp;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wp <= 1'b0;
			wa <= '0;
		end else if (CE && HREADY) begin
			wp <= HSEL && HTRANS[1] && HWRITE;
			wa <= HADDR[7:0];
		end
	end
	// shadow of the control words, updated in the data phase like the block but only while HREADY is high
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s0 <= SEL_RESET;
			s1 <= SEL_RESET;
			q0 <= QUAL_RESET;
			q1 <= QUAL_RESET;
		end else if (CE && HREADY && wp) begin
			if (wa == REG_EVENT_SELECT) begin
				s0 <= HWDATA[4:0];
				s1 <= HWDATA[SEL1_LSB +: 5];
			end
			if (wa == REG_QUALIFIER0)
				q0 <= HWDATA;
			if (wa == REG_QUALIFIER1)
				q1 <= HWDATA;
		end
	end
	assign e_wr = BUS.wr_valid && (q1[ACC_STALL_BIT] || BUS.wr_accept);
	assign e_cmd = BUS.cmd_valid && (q0[ACC_STALL_BIT] || BUS.cmd_accept);
	assign e_rsp = RSP.valid[q0[2:0]] && q0[RSP_TYPE_MSB - 2 + RSP.kind[q0[2:0]]];
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_sel0_addr;
		HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == REG_EVENT_SELECT;
	endsequence
	sequence s_sel0_unused;
		s_sel0_addr ##1 HREADY && (HWDATA[4:0] inside {5'h07, [5'h0C:5'h0F], [5'h12:5'h1F]});
	endsequence
	property p_unused;
		s_sel0_unused |=> ##1 INC[0] == '0;
	endproperty
	property p_read_bus;
		s0 == EV_READ_BUS |=> INC[0] == {4'h0, $past(BUS.rd_valid)};
	endproperty
	property p_cmd_bus;
		s0 == EV_COMMAND_BUS |=> INC[0] == {4'h0, $past(e_cmd)};
	endproperty
	property p_wr_bus;
		s1 == EV_WRITE_BUS |=> INC[1] == {4'h0, $past(e_wr)};
	endproperty
	property p_resp;
		s0 == EV_RESP_DWORDS |=> INC[0] == {4'h0, $past(e_rsp)};
	endproperty
	property p_io0;
		s0 == EV_IO_UNIT0 |=> INC[0] == {4'h0, $past(IO_UNIT0_SIDEBAND_INFO.valid)};
	endproperty
	property p_io1;
		s1 == EV_IO_UNIT1 |=> INC[1] == {4'h0, $past(IO_UNIT1_SIDEBAND_INFO.valid)};
	endproperty
	property p_req_idle;
		s0 == EV_REQUEST && !REQ.valid |=> INC[0] == '0;
	endproperty
	property p_req_port;
		s0 == EV_REQUEST && REQ.valid && !q0[REQ_PORT_LSB + REQ.port] |=> INC[0] == '0;
	endproperty
	property p_req_tgt;
		s0 == EV_REQUEST && REQ.valid && !q0[REQ_TGT_MSB - REQ.target] |=> INC[0] == '0;
	endproperty
	a_unused: assert property (p_unused) else $error("unassigned code counted");
	a_read_bus: assert property (p_read_bus) else $error("read bus count wrong");
	a_cmd_bus: assert property (p_cmd_bus) else $error("command bus count wrong");
	a_wr_bus: assert property (p_wr_bus) else $error("write bus count wrong");
	a_resp: assert property (p_resp) else $error("response dword count wrong");
	a_io0: assert property (p_io0) else $error("io unit 0 count wrong");
	a_io1: assert property (p_io1) else $error("io unit 1 count wrong");
	a_req_idle: assert property (p_req_idle) else $error("count without request");
	a_req_port: assert property (p_req_port) else $error("unselected port counted");
	a_req_tgt: assert property (p_req_tgt) else $error("unselected target counted");
endmodule // cpf_assertions

bind cpf_filter cpf_assertions i_cpf_assertions (
	.CLK(CLK), .RST_N(RST_N), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HWDATA(HWDATA), .HREADY(HREADY), .REQ(REQ), .BUS(BUS), .RSP(RSP),
	.IO_UNIT0_SIDEBAND_INFO(IO_UNIT0_SIDEBAND_INFO), .IO_UNIT1_SIDEBAND_INFO(IO_UNIT1_SIDEBAND_INFO), .INC(INC)
);

// *** cpf_far_model.sv ***
`timescale 1ns/100ps
module cpf_far_model
	import cpf_pkg::*;
(
	input  wire logic CLK,
	input  wire logic RST_N,
	input  wire logic RUN,
	output cpf_bus_s  BUS,
	output cpf_req_s  RD_START,
	output cpf_done_s RD_DONE
);
	logic [15:0] open_reads;
	// accept only with valid; random stalls exercise both accept-state readings
	always @(posedge CLK or negedge RST_N) begin
		cpf_bus_s   b;
		cpf_req_s   s;
		logic [3:0] t;
		logic [3:0] d;
		if (!RST_N) begin
			BUS <= '0;
			RD_START <= '0;
			RD_DONE <= '0;
			open_reads <= '0;
		end else begin
			b = cpf_bus_s'(5'($urandom) & {5{RUN}});
			b.wr_accept = b.wr_accept & b.wr_valid;
			b.cmd_accept = b.cmd_accept & b.cmd_valid;
			t = 4'($urandom);
			d = 4'($urandom);
			s = '0;
			s.valid = RUN & !open_reads[t] & 1'($urandom);
			s.port = 3'($urandom);
			s.cca = 3'($urandom % 5);
			s.target = 2'($urandom % 3);
			s.cmd = CMD_LEGACY_RD;
			s.tag = t;
			BUS <= b;
			RD_START <= s;
			// responses keep coming after RUN drops so open reads drain
			RD_DONE <= '{open_reads[d], d};
			open_reads <= (open_reads | (16'(s.valid) << t)) & ~(16'(open_reads[d]) << d);
		end
	end
endmodule // cpf_far_model

// *** cpf_filter.sv ***
`timescale 1ns/100ps
module cpf_filter
	import cpf_pkg::*;
(
	input  wire logic               CLK,
	input  wire logic               RST_N,
	input  wire logic               CE,
	input  wire logic               HSEL,
	input  wire logic [31:0]        HADDR,
	input  wire logic [1:0]         HTRANS,
	input  wire logic               HWRITE,
	input  wire logic [2:0]         HSIZE,
	input  wire logic [31:0]        HWDATA,
	input  wire logic               HREADY,
	output logic      [31:0]        HRDATA,
	output logic                    HREADYOUT,
	output logic                    HRESP,
	input  wire cpf_req_s           REQ,
	input  wire cpf_req_s           RD_START,
	input  wire cpf_done_s          RD_DONE,
	input  wire cpf_coh_s           COH,
	input  wire cpf_bus_s           BUS,
	input  wire cpf_share_s         SHARE,
	input  wire cpf_rsp_s           RSP,
	input  wire logic [5:0]         PIPE,
	input  wire cpf_hit_s           HIT,
	input  wire cpf_io_s            IO_UNIT0_SIDEBAND_INFO,
	input  wire cpf_io_s            IO_UNIT1_SIDEBAND_INFO,
	output logic [1:0][INC_W-1:0]   INC
);

	logic [1:0][4:0]       event_sel;
	logic [1:0][31:0]      qual;
	logic                  wr_pend;
	logic [7:0]            wr_addr;
	logic [1:0][INC_W-1:0] next_inc;
	logic [1:0][INC_W-1:0] pending;

	// request command after eviction reclassification
	function automatic cpf_cmd_e eff_cmd(input cpf_req_s r);
		if (r.cmd == CMD_LEGACY_WR && r.l1_evict && r.coh_mode)
			return CMD_EVICTION;
		return r.cmd;
	endfunction

	function automatic logic port_ok(input logic [31:0] q, input cpf_req_s r);
		return q[REQ_PORT_LSB + int'(r.port)];
	endfunction

	function automatic logic cca_ok(input logic [31:0] q, input cpf_req_s r);
		if (r.nc_cacheop)
			return 1'b1;
		if (r.cca > 3'h4)
			return 1'b0;
		return q[REQ_CCA_MSB - int'(r.cca)];
	endfunction

	function automatic logic tgt_ok(input logic [31:0] q, input cpf_req_s r);
		if (r.target > 2'h2)
			return 1'b0;
		return q[REQ_TGT_MSB - int'(r.target)];
	endfunction

	function automatic logic req_match(input logic [31:0] q, input cpf_req_s r);
		cpf_cmd_e c;
		logic     len_used;
		logic     len_ok;
		logic     cmd_ok;
		c = eff_cmd(r);
		len_used = (c == CMD_LEGACY_RD) || (c == CMD_LEGACY_WR) || (c == CMD_IO_COH_READ) ||
			(c == CMD_WINV_PARTIAL) || (c == CMD_WINV_FULL);
		len_ok = (r.len > 2'h2) ? 1'b0 : q[REQ_LEN_MSB - int'(r.len)];
		// read-always has no bit of its own and shares the load-miss bit
		if (c == CMD_READ_ALWAYS)
			cmd_ok = q[REQ_CMD_MSB - int'(CMD_LOAD_MISS)];
		else
			cmd_ok = q[REQ_CMD_MSB - int'(c)];
		// all groups must match, the length group only for commands that carry a length, the cca group only when nc_cacheop is clear
		return port_ok(q, r) && cca_ok(q, r) && (!len_used || len_ok) && cmd_ok && tgt_ok(q, r);
	endfunction

	function automatic logic rd_match(input logic [31:0] q, input cpf_req_s r);
		return port_ok(q, r) && cca_ok(q, r) && tgt_ok(q, r);
	endfunction

	function automatic logic coh_match(input logic [31:0] q, input cpf_coh_s c);
		logic st_ok;
		logic sp_ok;
		logic ic_ok;
		logic sc_ok;
		// bits 31..25 are never looked at
		st_ok = (c.istate > 3'h5) ? 1'b0 : q[COH_IST_MSB - int'(c.istate)];
		sp_ok = !c.spec_ok || (c.spec ? q[COH_SPEC_BIT] : q[COH_NOSP_BIT]);
		ic_ok = (c.icmd > 4'hD) ? 1'b0 : q[COH_ICMD_MSB - int'(c.icmd)];
		sc_ok = !c.sc_ok || ((c.sc_kind > 2'h2) ? 1'b0 : q[COH_SC_MSB - int'(c.sc_kind)]);
		return st_ok && sp_ok && ic_ok && sc_ok;
	endfunction

	function automatic logic share_match(input logic [31:0] q, input cpf_share_s s);
		logic is_read;
		is_read = (s.cmd == CMD_LOAD_MISS) || (s.cmd == CMD_IO_COH_READ) ||
			(s.cmd == CMD_STORE_MISS) || (s.cmd == CMD_READ_ALWAYS);
		if (!is_read || s.source > 3'h6)
			return 1'b0;
		return q[SRC_REQ_LSB + int'(s.req_port)] && q[SRC_DATA_LSB + int'(s.source)];
	endfunction

	function automatic logic rsp_match(input logic [31:0] q, input cpf_rsp_s r);
		logic [2:0] p;
		logic [1:0] k;
		p = q[RSP_PORT_LSB +: 3];
		k = r.kind[p];
		// only the one encoded port is looked at
		return r.valid[p] && (k <= 2'h2) && q[RSP_TYPE_MSB - (2 - int'(k))];
	endfunction

	function automatic logic hit_match(input logic [31:0] q, input cpf_hit_s h);
		logic kind_ok;
		logic al_ok;
		logic mg_ok;
		kind_ok = (h.kind > 4'h9) ? 1'b0 : q[HIT_KIND_MSB - (9 - int'(h.kind))];
		al_ok = !h.alloc_ok || (h.alloc ? q[HIT_ALLOC_BIT] : q[HIT_NOALC_BIT]);
		mg_ok = !h.merge_ok || (h.merged ? q[HIT_MERGE_BIT] : q[HIT_NOMRG_BIT]);
		return h.valid && kind_ok && al_ok && mg_ok && q[HIT_PORT_LSB + int'(h.port)];
	endfunction

	// ---------------- bus slave: zero wait states, always OKAY
	logic addr_ok;
	logic [7:0] addr_lo;
	assign addr_ok = HSEL && HREADY && HTRANS[1];
	assign addr_lo = {HADDR[7:2], 2'b00};

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			HREADYOUT <= 1'b0;
			HRESP     <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (CE) begin
			if (HREADY) begin
				wr_pend <= addr_ok && HWRITE;
				wr_addr <= addr_lo;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			event_sel <= {SEL_RESET, SEL_RESET};
			qual      <= {QUAL_RESET, QUAL_RESET};
		end else if (CE && wr_pend) begin
			unique case (wr_addr)
				REG_EVENT_SELECT: begin
					event_sel[0] <= HWDATA[4:0];
					event_sel[1] <= HWDATA[SEL1_LSB +: 5];
				end
				REG_QUALIFIER0: qual[0] <= HWDATA;
				REG_QUALIFIER1: qual[1] <= HWDATA;
				default: ;
			endcase
		end
	end

	// read data is ready for the data phase that follows the address phase
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= 32'h00000000;
		end else if (CE && HREADY) begin
			HRDATA <= 32'h00000000;
			if (addr_ok && !HWRITE) begin
				unique case (addr_lo)
					REG_EVENT_SELECT: HRDATA <= {19'h00000, event_sel[1], 3'h0, event_sel[0]};
					REG_QUALIFIER0:   HRDATA <= qual[0];
					REG_QUALIFIER1:   HRDATA <= qual[1];
					REG_ACTIVITY:     HRDATA <= {3'h0, pending[1], 3'h0, pending[0],
						3'h0, INC[1], 3'h0, INC[0]};
					default:          HRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	// ---------------- per-counter selection and matching
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic [(1<<TAG_W)-1:0] tracked;
		logic [INC_W-1:0]      open_cnt;
		logic                  start_hit;
		logic                  done_hit;
		logic                  start_new;

		// a tag is only tracked when the read itself matched
		assign start_hit = RD_START.valid && rd_match(qual[ch], RD_START);
		assign done_hit  = RD_DONE.valid && tracked[RD_DONE.tag];
		assign start_new = start_hit && !tracked[RD_START.tag];

		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				tracked <= '0;
			end else if (CE) begin
				if (done_hit)
					tracked[RD_DONE.tag] <= 1'b0;
				if (start_hit)
					tracked[RD_START.tag] <= 1'b1;
			end
		end

		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				open_cnt <= '0;
			end else if (CE) begin
				open_cnt <= INC_W'(open_cnt + INC_W'(start_new) - INC_W'(done_hit &&
					!(start_hit && RD_START.tag == RD_DONE.tag)));
			end
		end
		assign pending[ch] = open_cnt;

		always_comb begin
			next_inc[ch] = '0;
			// selection per counter
			unique case (event_sel[ch])
				EV_REQUEST:
					next_inc[ch] = INC_W'(REQ.valid && req_match(qual[ch], REQ));
				EV_COHERENT:
					next_inc[ch] = INC_W'(COH.valid && coh_match(qual[ch], COH));
				EV_WRITE_BUS:
					next_inc[ch] = INC_W'(qual[ch][ACC_STALL_BIT] ? BUS.wr_valid :
						(BUS.wr_valid && BUS.wr_accept));
				EV_COMMAND_BUS:
					next_inc[ch] = INC_W'(qual[ch][ACC_STALL_BIT] ? BUS.cmd_valid :
						(BUS.cmd_valid && BUS.cmd_accept));
				EV_READ_BUS:
					next_inc[ch] = INC_W'(BUS.rd_valid);
				EV_DATA_SOURCE:
					next_inc[ch] = INC_W'(SHARE.valid && share_match(qual[ch], SHARE));
				EV_RESP_DWORDS:
					next_inc[ch] = INC_W'(rsp_match(qual[ch], RSP));
				EV_PIPE_START:
					next_inc[ch] = INC_W'(|(PIPE & qual[ch][5:0]));
				EV_CACHE_OUT:
					next_inc[ch] = INC_W'(hit_match(qual[ch], HIT));
				EV_READ_REQ:
					next_inc[ch] = INC_W'(start_hit);
				EV_READ_WAIT:
					next_inc[ch] = open_cnt;
				EV_IO_UNIT0:
					next_inc[ch] = INC_W'(IO_UNIT0_SIDEBAND_INFO.valid);
				EV_IO_UNIT1:
					next_inc[ch] = INC_W'(IO_UNIT1_SIDEBAND_INFO.valid);
				default:
					next_inc[ch] = '0;
			endcase
		end

		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N)
				INC[ch] <= '0;
			else if (CE)
				INC[ch] <= next_inc[ch];
		end
	end

endmodule // cpf_filter

// *** cpf_filter_bench.sv ***
`timescale 1ns/100ps
module cpf_filter_bench
	import cpf_pkg::*;
;
	logic            CLK = 1'b0;
	logic            RST_N = 1'b0;
	logic            HSEL = 1'b0;
	logic            HWRITE = 1'b0;
	logic            run = 1'b0;
	logic [1:0]      HTRANS = 2'h0;
	logic [31:0]     HADDR = '0;
	logic [31:0]     HWDATA = '0;
	logic [31:0]     HRDATA;
	logic            HREADYOUT;
	logic            HRESP;
	cpf_req_s        REQ = '0;
	cpf_rsp_s        RSP = '0;
	logic [5:0]      PIPE = '0;
	cpf_io_s         IO0 = '0;
	cpf_io_s         IO1 = '0;
	cpf_bus_s        BUS;
	cpf_req_s        RD_START;
	cpf_done_s       RD_DONE;
	logic [1:0][4:0] INC;
	logic [4:0]      sel0 = 5'h1F;
	logic [4:0]      sel1 = 5'h1F;
	logic [31:0]     q0 = '1;
	logic [31:0]     q1 = '1;
	logic [1:0][4:0] expq[$];
	int              n_fail = 0;
	int              n_tests = 0;
	logic [15:0]     cfg[9] = '{16'h0000, 16'h0203, 16'h0304, 16'h0206, 16'h1110, 16'h0C07, 16'h1F12,
		16'h0A08, 16'h0B0A};
	logic [1:0][15:0] trk = '0;

	cpf_filter i_cpf_filter (
		.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .REQ(REQ), .RD_START(RD_START), .RD_DONE(RD_DONE), .COH('0), .BUS(BUS), .SHARE('0),
		.RSP(RSP), .PIPE(PIPE), .HIT('0), .IO_UNIT0_SIDEBAND_INFO(IO0), .IO_UNIT1_SIDEBAND_INFO(IO1), .INC(INC)
	);
	cpf_far_model i_cpf_far_model (
		.CLK(CLK), .RST_N(RST_N), .RUN(run), .BUS(BUS), .RD_START(RD_START), .RD_DONE(RD_DONE)
	);

	initial begin
		forever #5 CLK = ~CLK;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic hwait();
		int k;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (HREADYOUT !== 1'b1 && k < 64);
		if (k >= 64) begin
			n_fail++;
			complete_run();
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		hwait();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		hwait();
		r = HRDATA;
	endtask

	function automatic logic rd_hit(input logic [31:0] q);
		return RD_START.valid && q[24 + RD_START.port] && q[23 - RD_START.cca] && q[2 - RD_START.target];
	endfunction

	function automatic logic [4:0] f(input logic [4:0] s, input logic [31:0] q, input logic [15:0] tk);
		int   c;
		logic m;
		c = (REQ.l1_evict && REQ.coh_mode) ? int'(CMD_EVICTION) : int'(REQ.cmd);
		c = (c == int'(CMD_READ_ALWAYS)) ? 2 : c;
		m = c inside {0, 1, 4, 7, 8};
		case (s)
			EV_REQUEST: f = 5'(REQ.valid && q[24 + REQ.port] && (REQ.nc_cacheop || q[23 - REQ.cca])
				&& (!m || q[18 - REQ.len]) && q[15 - c] && q[2 - REQ.target]);
			EV_WRITE_BUS: f = 5'(BUS.wr_valid && (q[0] || BUS.wr_accept));
			EV_COMMAND_BUS: f = 5'(BUS.cmd_valid && (q[0] || BUS.cmd_accept));
			EV_READ_BUS: f = 5'(BUS.rd_valid);
			EV_RESP_DWORDS: f = 5'(RSP.valid[q[2:0]] && q[3 + RSP.kind[q[2:0]]]);
			EV_PIPE_START: f = 5'(|(PIPE & q[5:0]));
			EV_READ_REQ: f = 5'(rd_hit(q));
			EV_READ_WAIT: f = 5'($countones(tk));
			EV_IO_UNIT0: f = 5'(IO0.valid);
			EV_IO_UNIT1: f = 5'(IO1.valid);
			default: f = 5'h00;
		endcase
	endfunction

	// expected increments noted at the edge that registers INC, half a cycle ahead of the check, only the non-zero ones
	always @(posedge CLK) begin
		logic [1:0][4:0] e;
		e = {f(sel1, q1, trk[1]), f(sel0, q0, trk[0])};
		if (RST_N && e !== '0)
			expq.push_back(e);
		// tags are tracked per counter under the qualifier in force at the start
		for (int c = 0; c < 2; c++) begin
			if (RD_DONE.valid)
				trk[c][RD_DONE.tag] = 1'b0;
			if (rd_hit(c ? q1 : q0))
				trk[c][RD_START.tag] = 1'b1;
		end
	end

	always @(negedge CLK)
		if (INC !== '0)
			chk(INC, expq.size() ? expq.pop_front() : 'x);

	always @(posedge CLK) begin
		cpf_req_s r;
		cpf_rsp_s p;
		r = '0;
		r.valid = run & 1'($urandom);
		r.port = 3'($urandom);
		r.cca = 3'($urandom % 5);
		r.len = 2'($urandom % 3);
		r.target = 2'($urandom % 3);
		r.nc_cacheop = 1'($urandom);
		r.coh_mode = 1'($urandom);
		r.l1_evict = 1'($urandom);
		// evictions only as legacy write or coherent eviction, both readings then agree
		r.cmd = cpf_cmd_e'(r.l1_evict ? 6 * ($urandom % 2) : $urandom % 14);
		for (int i = 0; i < 8; i++) begin
			p.valid[i] = run & 1'($urandom);
			p.kind[i] = 2'($urandom % 3);
		end
		REQ <= r;
		RSP <= p;
		PIPE <= 6'($urandom) & {6{run}};
		IO0 <= {run & 1'($urandom), 31'($urandom)};
		IO1 <= {run & 1'($urandom), 31'($urandom)};
	end

	initial begin
		logic [31:0] r;
		logic [31:0] a;
		logic [31:0] b;
		void'($urandom(32'hCA71));
		repeat (16) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (2) @(posedge CLK);
		ahb(1'b0, REG_EVENT_SELECT, '0, r);
		chk(r, 32'h00001F1F);
		ahb(1'b0, REG_QUALIFIER1, '0, r);
		chk(r, QUAL_RESET);
		ahb(1'b0, 8'h10, '0, r);
		chk(r, 32'h00000000);
		for (int k = 0; k < 2; k++)
			foreach (cfg[i]) begin
				a = (($urandom | $urandom) & 32'hFFFFFFFE) | 32'(k);
				b = k ? ($urandom | $urandom) : '1;
				ahb(1'b1, REG_EVENT_SELECT, 32'(cfg[i]), r);
				ahb(1'b1, REG_QUALIFIER0, a, r);
				ahb(1'b1, REG_QUALIFIER1, b, r);
				ahb(1'b0, REG_EVENT_SELECT, '0, r);
				chk(r, 32'(cfg[i]) & 32'h00001F1F);
				ahb(1'b0, REG_QUALIFIER0, '0, r);
				chk(r, a);
				sel0 = cfg[i][4:0];
				sel1 = cfg[i][12:8];
				q0 = a;
				q1 = b;
				run <= 1'b1;
				repeat (300) @(posedge CLK);
				run <= 1'b0;
				// long tail lets open reads drain before the selection changes
				repeat (200) @(posedge CLK);
				chk(expq.size(), 0);
			end
		complete_run();
	end
endmodule // cpf_filter_bench

// *** cpf_pkg.sv ***
package cpf_pkg;

	// event numbers
	localparam logic [4:0] EV_REQUEST     = 5'h00;
	localparam logic [4:0] EV_COHERENT    = 5'h01;
	localparam logic [4:0] EV_WRITE_BUS   = 5'h02;
	localparam logic [4:0] EV_COMMAND_BUS = 5'h03;
	localparam logic [4:0] EV_READ_BUS    = 5'h04;
	localparam logic [4:0] EV_DATA_SOURCE = 5'h05;
	localparam logic [4:0] EV_RESP_DWORDS = 5'h06;
	localparam logic [4:0] EV_PIPE_START  = 5'h08;
	localparam logic [4:0] EV_CACHE_OUT   = 5'h09;
	localparam logic [4:0] EV_READ_REQ    = 5'h0A;
	localparam logic [4:0] EV_READ_WAIT   = 5'h0B;
	localparam logic [4:0] EV_IO_UNIT0    = 5'h10;
	localparam logic [4:0] EV_IO_UNIT1    = 5'h11;

	// request qualifier layout
	localparam int REQ_PORT_LSB = 24;
	localparam int REQ_CCA_MSB  = 23;
	localparam int REQ_LEN_MSB  = 18;
	localparam int REQ_CMD_MSB  = 15;
	localparam int REQ_TGT_MSB  = 2;
	// coherent request/response qualifier layout
	localparam int COH_IST_MSB  = 24;
	localparam int COH_SPEC_BIT = 18;
	localparam int COH_NOSP_BIT = 17;
	localparam int COH_ICMD_MSB = 16;
	localparam int COH_SC_MSB   = 2;
	// other qualifier layouts
	localparam int ACC_STALL_BIT = 0;
	localparam int SRC_REQ_LSB   = 7;
	localparam int SRC_DATA_LSB  = 0;
	localparam int RSP_TYPE_MSB  = 5;
	localparam int RSP_PORT_LSB  = 0;
	localparam int HIT_KIND_MSB  = 17;
	localparam int HIT_ALLOC_BIT = 19;
	localparam int HIT_NOALC_BIT = 18;
	localparam int HIT_MERGE_BIT = 21;
	localparam int HIT_NOMRG_BIT = 20;
	localparam int HIT_PORT_LSB  = 0;

	// register byte offsets
	localparam logic [7:0] REG_EVENT_SELECT = 8'h00;
	localparam logic [7:0] REG_QUALIFIER0   = 8'h04;
	localparam logic [7:0] REG_QUALIFIER1   = 8'h08;
	localparam logic [7:0] REG_ACTIVITY     = 8'h0C;
	localparam int         SEL1_LSB         = 8;
	localparam logic [31:0] QUAL_RESET      = 32'hFFFFFFFF;
	localparam logic [4:0]  SEL_RESET       = 5'h1F;

	localparam int TAG_W = 4;
	localparam int INC_W = 5;

	typedef enum logic [3:0] {
		CMD_LEGACY_WR    = 4'h0,
		CMD_LEGACY_RD    = 4'h1,
		CMD_LOAD_MISS    = 4'h2,
		CMD_STORE_MISS   = 4'h3,
		CMD_IO_COH_READ  = 4'h4,
		CMD_UPGRADE      = 4'h5,
		CMD_EVICTION     = 4'h6,
		CMD_WINV_PARTIAL = 4'h7,
		CMD_WINV_FULL    = 4'h8,
		CMD_LINE_INVAL   = 4'h9,
		CMD_COPYOUT      = 4'hA,
		CMD_COPYOUT_INV  = 4'hB,
		CMD_BARRIER      = 4'hC,
		CMD_READ_ALWAYS  = 4'hD
	} cpf_cmd_e;

	typedef struct packed {
		logic             valid;
		logic [2:0]       port;
		logic [2:0]       cca;       // 0 write-through .. 4 coherent shared
		logic [1:0]       len;       // 0:1, 1:2, 2:4 dwords
		cpf_cmd_e         cmd;
		logic [1:0]       target;    // 0 memory, 1 control space, 2 io space
		logic             nc_cacheop;
		logic             l1_evict;
		logic             coh_mode;
		logic [TAG_W-1:0] tag;
	} cpf_req_s;

	typedef struct packed {
		logic             valid;
		logic [TAG_W-1:0] tag;
	} cpf_done_s;

	typedef struct packed {
		logic       valid;
		logic [2:0] istate;    // 0 excl+data .. 4 shared, 5 invalid
		logic       spec_ok;
		logic       spec;
		logic [3:0] icmd;      // 0..13, highest qualifier bit first
		logic       sc_ok;
		logic [1:0] sc_kind;   // 0 plain, 1 kept, 2 cancelled
	} cpf_coh_s;

	typedef struct packed {
		logic wr_valid;
		logic wr_accept;
		logic cmd_valid;
		logic cmd_accept;
		logic rd_valid;
	} cpf_bus_s;

	typedef struct packed {
		logic       valid;
		cpf_cmd_e   cmd;
		logic [2:0] req_port;
		logic [2:0] source;    // 0 L2/memory, n processor on port n-1
	} cpf_share_s;

	typedef struct packed {
		logic [7:0]      valid;
		logic [7:0][1:0] kind; // 0 ok, 1 write ack, 2 read data
	} cpf_rsp_s;

	typedef struct packed {
		logic       valid;
		logic [3:0] kind;      // 0 read miss .. 9 other
		logic [2:0] port;
		logic       alloc_ok;
		logic       alloc;
		logic       merge_ok;
		logic       merged;
	} cpf_hit_s;

	typedef struct packed {
		logic        valid;
		logic [30:0] info;
	} cpf_io_s;

endpackage
